/* File: cmsf_pkg.sv */
// Package for the clock mode select block: register map, field layout,
// reset values, mode encodings and fixed ratios.
// Assumes an 8-bit register port and a single 10 MHz system clock.
package cmsf_pkg;

    // Register offsets.
    localparam logic [1:0] CTRL_ONE_OFS  = 2'h0;
    localparam logic [1:0] CTRL_TWO_OFS  = 2'h1;
    localparam logic [1:0] STATUS_OFS    = 2'h2;

    // Control register one fields.
    localparam int HGO_BIT     = 7;
    localparam int RANGE_BIT   = 6;
    localparam int REFERENCE_SELECT_BIT    = 5;
    localparam int REQ_LSB     = 3;
    localparam int OSCSTEN_BIT = 2;
    localparam int LOCD_BIT    = 1;
    // Control register two fields.
    localparam int MFD_LSB     = 4;
    localparam int RFD_LSB     = 0;
    // Status register fields.
    localparam int ACT_LSB     = 0;
    localparam int DCO_STABLE_FLAG_BIT    = 2;
    localparam int EXT_REF_STATUS_BIT    = 3;
    localparam int LOSS_OF_CLOCK_FLAG_BIT    = 4;
    localparam int LOCK_BIT    = 5;

    // Reset values.
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;

    // Requested / actual mode codes.
    localparam logic [1:0] CODE_SCM = 2'h0;
    localparam logic [1:0] CODE_FEI = 2'h1;
    localparam logic [1:0] CODE_FBE = 2'h2;
    localparam logic [1:0] CODE_FEE = 2'h3;

    // Timing and ratio constants.
    localparam int         CLK_PERIOD_NS   = 100;
    localparam int         SETTLE_NS       = 400;
    localparam int         SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] INT_REF_DIV     = 4'h7;
    localparam logic [3:0] FFC_DIV         = 4'h2;
    localparam logic [3:0] BUS_DIV         = 4'h2;
    localparam logic [6:0] PRESCALE_LOW    = 7'h40;
    localparam logic [6:0] PRESCALE_HIGH   = 7'h01;
    localparam logic [4:0] MULT_BASE       = 5'h04;
    localparam logic [12:0] FFC_MIN_RATIO  = 13'h0004;
    localparam logic [7:0] CMP_INT_PERIODS = 8'h08;
    localparam logic [7:0] CMP_EXT_LOW     = 8'h02;
    localparam logic [7:0] CMP_EXT_HIGH    = 8'h80;

    // Internal mode states, Gray along off, scm, fei, fee, fbe.
    typedef enum logic [2:0] {
        CMSF_OFF = 3'h0,
        CMSF_SCM = 3'h1,
        CMSF_FEI = 3'h3,
        CMSF_FEE = 3'h2,
        CMSF_FBE = 3'h6
    } cmsf_mode_t;

    // Status conditions from the oscillator and loop monitors.
    typedef struct packed {
        logic dco_stable;
        logic ext_ref_ok;
        logic loss_of_clock;
        logic fll_lock;
    } cmsf_stat_t;

    // Decoded loop settings handed to the loop.
    typedef struct packed {
        logic [6:0] prescale;
        logic [4:0] mult_n;
        logic [7:0] div_r;
        logic [7:0] cmp_periods;
        logic       cmp_uses_ext;
    } cmsf_loop_t;

endpackage : cmsf_pkg

/* File: cmsf_tick_div.sv */
// Divides a one-cycle enable pulse stream by a programmable count.
// Assumes i_tick is one cycle wide and synchronous to i_clk.
`timescale 1ns/1ps
module cmsf_tick_div #(
    parameter int W = 9
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_clr,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_div,
    output logic              o_tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } cmsf_div_st_t;

    cmsf_div_st_t st_q;
    cmsf_div_st_t st_d;

    always_comb begin
        st_d       = st_q;
        st_d.pulse = 1'b0;
        if (i_clr) begin
            st_d.cnt = '0;
        end else if (i_tick) begin
            if (st_q.cnt >= i_div - W'(1)) begin
                st_d.cnt   = '0;
                st_d.pulse = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_tick = st_q.pulse;
endmodule : cmsf_tick_div

/* File: cmsf_once_reg.sv */
// Register that takes only the first write after reset and then holds.
// Assumes i_wr is a one-cycle strobe.
`timescale 1ns/1ps
module cmsf_once_reg #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_wr,
    input  wire logic [W-1:0] i_d,
    output logic [W-1:0]      o_q,
    output logic              o_taken
);
    typedef struct packed {
        logic         taken;
        logic [W-1:0] val;
    } cmsf_once_st_t;

    cmsf_once_st_t st_q;
    cmsf_once_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (i_wr && !st_q.taken) begin
            st_d.taken = 1'b1;
            st_d.val   = i_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q <= '{taken: 1'b0, val: RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_q     = st_q.val;
    assign o_taken = st_q.taken;
endmodule : cmsf_once_reg

/* File: cmsf_top.sv */
// Clock mode select and output clock forming for the frequency locked loop.
// All clocks are modelled as one-cycle enable pulses on the 10 MHz i_clk;
// the oscillator, reference and loop monitors live outside this block.
`timescale 1ns/1ps
// How it works
// - Software requests mode; status shows actual mode.
// - First write freezes reference select; a frozen zero keeps amp off.
// - Actual mode updates several cycles after request.
// - Mode follows request when status conditions hold.
// - Fallback to self-clocked or bypass, or internal loop held; off gives nothing.
// - External locked loop halves output until locked.
// - Fixed clock equals bus clock otherwise.
// - External locked: reference/2 when ratio and lock.
// - Fixed clock off in internal and self-clocked.
// - High gain bit picks high-gain oscillator.
// - High gain only counts with reference select.
// - High gain bit takes one write only.
// - Prescale 64 low range, 1 high range.
// - Self-clocked: oscillator divided by R, about 8 MHz.
// - Bypass: external reference divided by R.
// - Internal loop reference is internal reference/7.
module cmsf_top (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [1:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    input  wire logic              i_stop,
    input  wire logic              i_dco_tick,
    input  wire logic              i_ext_tick,
    input  wire logic              i_int_tick,
    input  wire cmsf_pkg::cmsf_stat_t i_stat,
    output logic                   o_gen_clk_tick,
    output logic                   o_bus_clk_tick,
    output logic                   o_fixed_freq_tick,
    output logic                   o_fixed_freq_off,
    output logic                   o_fll_ref_tick,
    output logic                   o_osc_amp_en,
    output logic                   o_high_gain,
    output cmsf_pkg::cmsf_loop_t   o_loop
);
    typedef struct packed {
        cmsf_pkg::cmsf_mode_t mode;
        logic [1:0]           req;
        logic                 rng;
        logic                 oscsten;
        logic                 locd;
        logic [2:0]           multiply_factor_field;
        logic [2:0]           divide_factor_field;
        logic [3:0]           settle;
        logic                 locked_once;
        logic [7:0]           rdata;
        logic                 ffc_tick;
        cmsf_pkg::cmsf_loop_t loop;
    } cmsf_top_st_t;

    cmsf_top_st_t st_q;
    cmsf_top_st_t st_d;

    logic       wr_one;
    logic       wr_two;
    logic       reference_select_q;
    logic       hgo_q;
    logic       reference_select_taken;
    logic       hgo_taken;
    logic [7:0] r_val;
    logic [4:0] n_val;
    logic [8:0] gen_div;
    logic       gen_src;
    logic       gen_tick;
    logic       bus_tick;
    logic       ext_half;
    logic       int_sev;
    logic       mode_chg;
    logic       ratio_ok;
    logic [12:0] pn_prod;
    logic [1:0] act_code;
    cmsf_pkg::cmsf_mode_t nxt_mode;

    assign wr_one = i_wr && (i_addr == cmsf_pkg::CTRL_ONE_OFS);
    assign wr_two = i_wr && (i_addr == cmsf_pkg::CTRL_TWO_OFS);

    // Reference select is frozen by the first write, whatever it holds.
    cmsf_once_reg #(.W(1), .RST(1'b0)) u_reference_select_once (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr      (wr_one),
        .i_d       (i_wdata[cmsf_pkg::REFERENCE_SELECT_BIT]),
        .o_q       (reference_select_q),
        .o_taken   (reference_select_taken)
    );

    cmsf_once_reg #(.W(1), .RST(1'b0)) u_hgo_once (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr      (wr_one),
        .i_d       (i_wdata[cmsf_pkg::HGO_BIT]),
        .o_q       (hgo_q),
        .o_taken   (hgo_taken)
    );

    // Factor decodes.
    assign n_val   = cmsf_pkg::MULT_BASE + {1'b0, st_q.multiply_factor_field, 1'b0};
    assign r_val   = 8'h01 << st_q.divide_factor_field;
    assign pn_prod = 13'(st_q.loop.prescale) * 13'(n_val);
    assign ratio_ok = pn_prod >= (cmsf_pkg::FFC_MIN_RATIO << st_q.divide_factor_field);

    // Mode resolution from request and monitor status.
    always_comb begin
        nxt_mode = st_q.mode;
        if (i_stop) begin
            nxt_mode = cmsf_pkg::CMSF_OFF;
        end else begin
            case (st_q.req)
                cmsf_pkg::CODE_SCM: begin
                    nxt_mode = cmsf_pkg::CMSF_SCM;
                end
                cmsf_pkg::CODE_FEI: begin
                    nxt_mode = i_stat.dco_stable ? cmsf_pkg::CMSF_FEI
                                                 : cmsf_pkg::CMSF_SCM;
                end
                cmsf_pkg::CODE_FBE: begin
                    if (i_stat.ext_ref_ok) begin
                        nxt_mode = cmsf_pkg::CMSF_FBE;
                    end else if (st_q.mode != cmsf_pkg::CMSF_OFF) begin
                        nxt_mode = cmsf_pkg::CMSF_SCM;
                    end
                end
                default: begin
                    if (st_q.mode == cmsf_pkg::CMSF_FBE && i_stat.loss_of_clock
                        && i_stat.ext_ref_ok) begin
                        nxt_mode = cmsf_pkg::CMSF_FBE;
                    end else if (i_stat.dco_stable && i_stat.ext_ref_ok
                                 && !(st_q.mode == cmsf_pkg::CMSF_FEE
                                      && i_stat.loss_of_clock)) begin
                        nxt_mode = cmsf_pkg::CMSF_FEE;
                    end else if (i_stat.ext_ref_ok && st_q.mode == cmsf_pkg::CMSF_FEE) begin
                        nxt_mode = cmsf_pkg::CMSF_FBE;
                    end else if (st_q.mode == cmsf_pkg::CMSF_FEI && i_stat.dco_stable) begin
                        nxt_mode = cmsf_pkg::CMSF_FEI;
                    end else begin
                        nxt_mode = cmsf_pkg::CMSF_SCM;
                    end
                end
            endcase
        end
    end

    always_comb begin
        st_d          = st_q;
        st_d.ffc_tick = 1'b0;
        if (wr_one) begin
            st_d.req     = i_wdata[cmsf_pkg::REQ_LSB +: 2];
            st_d.rng     = i_wdata[cmsf_pkg::RANGE_BIT];
            st_d.oscsten = i_wdata[cmsf_pkg::OSCSTEN_BIT];
            st_d.locd    = i_wdata[cmsf_pkg::LOCD_BIT];
            st_d.settle  = 4'(cmsf_pkg::SETTLE_CYCLES);
        end else if (st_q.settle != 4'h0) begin
            st_d.settle = st_q.settle - 4'h1;
        end else begin
            st_d.mode = nxt_mode;
        end
        if (wr_two) begin
            st_d.multiply_factor_field = i_wdata[cmsf_pkg::MFD_LSB +: 3];
            st_d.divide_factor_field = i_wdata[cmsf_pkg::RFD_LSB +: 3];
        end
        // Lock history: relock after a multiply change starts halved again.
        if (st_q.mode != cmsf_pkg::CMSF_FEE || (wr_two
            && i_wdata[cmsf_pkg::MFD_LSB +: 3] != st_q.multiply_factor_field)) begin
            st_d.locked_once = 1'b0;
        end else if (i_stat.fll_lock) begin
            st_d.locked_once = 1'b1;
        end
        // Fixed-frequency clock selection.
        case (st_q.mode)
            cmsf_pkg::CMSF_FEE: begin
                st_d.ffc_tick = (ratio_ok && i_stat.fll_lock) ? ext_half
                                                              : bus_tick;
            end
            cmsf_pkg::CMSF_FEI, cmsf_pkg::CMSF_SCM: begin
                st_d.ffc_tick = 1'b0;
            end
            default: begin
                st_d.ffc_tick = bus_tick;
            end
        endcase
        st_d.loop.prescale     = st_q.rng ? cmsf_pkg::PRESCALE_HIGH
                                          : cmsf_pkg::PRESCALE_LOW;
        st_d.loop.mult_n       = n_val;
        st_d.loop.div_r        = r_val;
        st_d.loop.cmp_uses_ext = (st_q.mode == cmsf_pkg::CMSF_FEE);
        if (st_q.mode == cmsf_pkg::CMSF_FEE) begin
            st_d.loop.cmp_periods = st_q.rng ? cmsf_pkg::CMP_EXT_HIGH
                                             : cmsf_pkg::CMP_EXT_LOW;
        end else begin
            st_d.loop.cmp_periods = cmsf_pkg::CMP_INT_PERIODS;
        end
        st_d.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                cmsf_pkg::CTRL_ONE_OFS: begin
                    st_d.rdata = {hgo_q, st_q.rng, reference_select_q, st_q.req, st_q.oscsten,
                                  st_q.locd, 1'b0};
                end
                cmsf_pkg::CTRL_TWO_OFS: begin
                    st_d.rdata = {1'b0, st_q.multiply_factor_field, 1'b0, st_q.divide_factor_field};
                end
                cmsf_pkg::STATUS_OFS: begin
                    st_d.rdata = {2'h0, i_stat.fll_lock, i_stat.loss_of_clock,
                                  i_stat.ext_ref_ok, i_stat.dco_stable, act_code};
                end
                default: begin
                    st_d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q             <= '0;
            st_q.mode        <= cmsf_pkg::CMSF_SCM;
            st_q.loop.prescale    <= cmsf_pkg::PRESCALE_LOW;
            st_q.loop.mult_n      <= cmsf_pkg::MULT_BASE;
            st_q.loop.div_r       <= 8'h01;
            st_q.loop.cmp_periods <= cmsf_pkg::CMP_INT_PERIODS;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        case (st_q.mode)
            cmsf_pkg::CMSF_FEI: act_code = cmsf_pkg::CODE_FEI;
            cmsf_pkg::CMSF_FBE: act_code = cmsf_pkg::CODE_FBE;
            cmsf_pkg::CMSF_FEE: act_code = cmsf_pkg::CODE_FEE;
            default:            act_code = cmsf_pkg::CODE_SCM;
        endcase
    end

    // Output clock source and divide; off feeds nothing to the divider.
    always_comb begin
        case (st_q.mode)
            cmsf_pkg::CMSF_FBE: gen_src = i_ext_tick;
            cmsf_pkg::CMSF_OFF: gen_src = 1'b0;
            default:            gen_src = i_dco_tick;
        endcase
    end
    assign gen_div = (st_q.mode == cmsf_pkg::CMSF_FEE && !st_q.locked_once)
                   ? {r_val, 1'b0} : {1'b0, r_val};
    // Restarting the divider on a mode change avoids a runt first period.
    assign mode_chg = st_d.mode != st_q.mode;

    cmsf_tick_div #(.W(9)) u_gen_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_clr     (mode_chg),
        .i_tick    (gen_src),
        .i_div     (gen_div),
        .o_tick    (gen_tick)
    );

    cmsf_tick_div #(.W(4)) u_bus_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_clr     (1'b0),
        .i_tick    (gen_tick),
        .i_div     (cmsf_pkg::BUS_DIV),
        .o_tick    (bus_tick)
    );

    cmsf_tick_div #(.W(4)) u_ffc_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_clr     (1'b0),
        .i_tick    (i_ext_tick),
        .i_div     (cmsf_pkg::FFC_DIV),
        .o_tick    (ext_half)
    );

    cmsf_tick_div #(.W(4)) u_irg_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_clr     (1'b0),
        .i_tick    (i_int_tick),
        .i_div     (cmsf_pkg::INT_REF_DIV),
        .o_tick    (int_sev)
    );

    assign o_rdata           = st_q.rdata;
    assign o_gen_clk_tick    = gen_tick;
    assign o_bus_clk_tick    = bus_tick;
    assign o_fixed_freq_tick = st_q.ffc_tick;
    assign o_fixed_freq_off  = (st_q.mode == cmsf_pkg::CMSF_FEI)
                            || (st_q.mode == cmsf_pkg::CMSF_SCM);
    assign o_fll_ref_tick    = (st_q.mode == cmsf_pkg::CMSF_FEE) ? i_ext_tick : int_sev;
    // A frozen zero reference select keeps the amplifier off until reset.
    assign o_osc_amp_en      = reference_select_q && st_q.req[1]
                            && (st_q.mode != cmsf_pkg::CMSF_OFF || st_q.oscsten);
    assign o_high_gain       = hgo_q && reference_select_q;
    assign o_loop            = st_q.loop;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_off_held;
        st_q.mode == cmsf_pkg::CMSF_OFF [*3];
    endsequence

    sequence s_int_modes;
        (st_q.mode == cmsf_pkg::CMSF_FEI || st_q.mode == cmsf_pkg::CMSF_SCM) [*2];
    endsequence

    a_off_no_clock: assert property (s_off_held |-> !o_gen_clk_tick)
        else $error("output clock ticks while off");
    a_settle_hold: assert property (wr_one |=> $stable(st_q.mode) [*4])
        else $error("actual mode changed too soon after request");
    a_fei_entry: assert property (st_q.mode == cmsf_pkg::CMSF_FEI
        && $past(st_q.mode) != cmsf_pkg::CMSF_FEI |-> $past(i_stat.dco_stable))
        else $error("internal loop mode entered without stable oscillator");
    a_fee_entry: assert property (st_q.mode == cmsf_pkg::CMSF_FEE
        && $past(st_q.mode) != cmsf_pkg::CMSF_FEE
        |-> $past(i_stat.dco_stable) && $past(i_stat.ext_ref_ok))
        else $error("external loop mode entered without both conditions");
    a_fbe_entry: assert property (st_q.mode == cmsf_pkg::CMSF_FBE
        && $past(st_q.mode) != cmsf_pkg::CMSF_FBE |-> $past(i_stat.ext_ref_ok))
        else $error("bypass mode entered without external reference");
    a_ffc_off: assert property (s_int_modes |-> !o_fixed_freq_tick)
        else $error("fixed clock ticks in internal modes");
    a_reference_select_frozen: assert property (reference_select_taken && !reference_select_q |-> !o_osc_amp_en)
        else $error("amplifier enabled with frozen zero reference select");
    a_hgo_once: assert property (hgo_taken && wr_one |=> $stable(hgo_q) [*2])
        else $error("high gain bit changed after first write");
    a_hgo_gated: assert property (o_high_gain |-> reference_select_q && hgo_q)
        else $error("high gain without reference select");
    a_fee_halved: assert property (st_q.mode == cmsf_pkg::CMSF_FEE && !st_q.locked_once
        |-> gen_div == {r_val, 1'b0})
        else $error("external loop not halved before lock");
endmodule : cmsf_top

/* File: cmsf_ext_src.sv */
// Far-side model: an external clock source or crystal feeding the block.
// Assumes the bench tells it whether a source is fitted; runs on i_clk.
`timescale 1ns/1ps
module cmsf_ext_src #(
    parameter int DIV = 3
) (
    input  wire logic i_clk,
    input  wire logic i_present,
    output logic      o_tick,
    output logic      o_ok
);
    int cnt_q = 0;
    // A missing source gives no edges at all, never a stale one.
    always @(posedge i_clk) begin
        cnt_q  <= (cnt_q + 1) % DIV;
        o_tick <= i_present && (cnt_q == 0);
    end
    assign o_ok = i_present;
endmodule : cmsf_ext_src

/* File: testbench.sv */
// Self-checking bench for the clock mode select block.
// Assumes a 10 MHz clock, a synchronous reset and a one-cycle read latency.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    logic                 i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [1:0]           i_addr = 2'h0;
    logic [7:0]           i_wdata = 8'h00, rd_v;
    logic                 int_tick = 1'b0, dco_ok = 1'b0, present = 1'b0, lock = 1'b0;
    logic                 ext_tick, ext_ok, gen_tick, ff_tick, ff_off, amp_en, high_gain;
    logic                 loss = 1'b0, stop = 1'b0, bus_tick, ref_tick;
    logic [7:0]           rdata;
    cmsf_pkg::cmsf_stat_t stat;
    cmsf_pkg::cmsf_loop_t loop_s;
    int                   num_errors = 0, compares = 0, seed = 87, m, cnt, fcnt, bcnt, rcnt;
    int                   req, multiply_factor_field, divide_factor_field, rng;
    logic [31:0]          v;
    assign stat = '{dco_ok, ext_ok, loss, lock};
    cmsf_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_stop(stop),
        .i_dco_tick(1'b1), .i_ext_tick(ext_tick), .i_int_tick(int_tick), .i_stat(stat),
        .o_gen_clk_tick(gen_tick), .o_bus_clk_tick(bus_tick), .o_fixed_freq_tick(ff_tick),
        .o_fixed_freq_off(ff_off), .o_fll_ref_tick(ref_tick), .o_osc_amp_en(amp_en),
        .o_high_gain(high_gain), .o_loop(loop_s));
    cmsf_ext_src ext_u (.i_clk(i_clk), .i_present(present), .o_tick(ext_tick),
        .o_ok(ext_ok));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) int_tick <= ~int_tick;
    task automatic do_reset();
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
    endtask : do_reset
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Model of the mode reached from self-clocked mode after one request.
    function automatic logic [1:0] exp_act(int r, int d, int e);
        case (r)
            1: return d ? 2'h1 : 2'h0;
            2: return e ? 2'h2 : 2'h0;
            3: return (d && e) ? 2'h3 : 2'h0;
            default: return 2'h0;
        endcase
    endfunction : exp_act
    // Tick counts are checked against a window, since the dividers start mid-phase.
    function automatic logic in_rng(int x, int lo, int hi);
        return logic'(x >= lo && x <= hi);
    endfunction : in_rng
    task automatic count_ticks(input int n);
        cnt = 0; bcnt = 0; fcnt = 0; rcnt = 0;
        repeat (n) begin
            @(posedge i_clk);
            #1;
            cnt += int'(gen_tick === 1'b1);
            bcnt += int'(bus_tick === 1'b1);
            fcnt += int'(ff_tick === 1'b1);
            rcnt += int'(ref_tick === 1'b1);
        end
    endtask : count_ticks
    task automatic close_out();
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    initial begin
        #5000000 num_errors++;
        close_out();
    end
    initial begin
        do_reset();
        for (m = 0; m < 4; m++) begin
            rd_reg(m[1:0], rd_v);
            `CHK(rd_v & 8'hC3, 8'h00)
        end
        `CHK(loop_s, cmsf_pkg::cmsf_loop_t'({7'h40, 5'h04, 8'h01, 8'h08, 1'b0}))
        for (m = 0; m < 16; m++) begin
            req = m / 4;
            do_reset();
            dco_ok <= m[1]; present <= m[0];
            wr_reg(2'h0, 8'h20 | 8'(req << 3));
            rd_reg(2'h2, rd_v);
            `CHK(rd_v[1:0], 2'h0)
            repeat (8) @(posedge i_clk);
            rd_reg(2'h2, rd_v);
            `CHK(rd_v[1:0], exp_act(req, m[1], m[0]))
            `CHK(ff_off, logic'(exp_act(req, m[1], m[0]) < 2))
            `CHK(amp_en, logic'(req >= 2))
        end
        for (m = 0; m < 8; m++) begin
            v = $random(seed); multiply_factor_field = v[6:4]; divide_factor_field = v[2:0]; rng = v[8];
            wr_reg(2'h1, 8'((multiply_factor_field << 4) | divide_factor_field));
            wr_reg(2'h0, 8'h20 | 8'(rng << 6));
            repeat (2) @(posedge i_clk);
            #1;
            `CHK(loop_s.mult_n, 5'(4 + 2 * multiply_factor_field))
            `CHK(loop_s.div_r, 8'(1 << divide_factor_field))
            `CHK(loop_s.prescale, rng ? 7'h01 : 7'h40)
        end
        do_reset();
        wr_reg(2'h0, 8'hA0);
        wr_reg(2'h0, 8'h20);
        rd_reg(2'h0, rd_v);
        `CHK(rd_v[7], 1'b1)
        `CHK(high_gain, 1'b1)
        do_reset();
        wr_reg(2'h0, 8'h80);
        wr_reg(2'h0, 8'hB0);
        rd_reg(2'h0, rd_v);
        `CHK(rd_v[5], 1'b0)
        `CHK(high_gain, 1'b0)
        `CHK(amp_en, 1'b0)
        do_reset();
        wr_reg(2'h1, 8'h02);
        repeat (8) @(posedge i_clk);
        count_ticks(140);
        `CHK(in_rng(cnt, 34, 36), 1'b1)
        `CHK(in_rng(bcnt, 16, 19), 1'b1)
        `CHK(fcnt, 0)
        `CHK(in_rng(rcnt, 9, 11), 1'b1)
        do_reset();
        dco_ok <= 1'b0; present <= 1'b1;
        wr_reg(2'h1, 8'h00);
        wr_reg(2'h0, 8'h30);
        repeat (8) @(posedge i_clk);
        count_ticks(60);
        `CHK(in_rng(cnt, 19, 21), 1'b1)
        `CHK(in_rng(fcnt, 9, 11), 1'b1)
        dco_ok <= 1'b1; loss <= 1'b1;
        wr_reg(2'h0, 8'h38);
        repeat (8) @(posedge i_clk);
        rd_reg(2'h2, rd_v);
        `CHK(rd_v[1:0], 2'h2)
        loss <= 1'b0;
        repeat (8) @(posedge i_clk);
        rd_reg(2'h2, rd_v);
        `CHK(rd_v[1:0], 2'h3)
        count_ticks(60);
        `CHK(in_rng(cnt, 29, 31), 1'b1)
        `CHK(in_rng(fcnt, 14, 16), 1'b1)
        lock <= 1'b1;
        repeat (4) @(posedge i_clk);
        count_ticks(60);
        `CHK(in_rng(cnt, 59, 61), 1'b1)
        `CHK(in_rng(fcnt, 9, 11), 1'b1)
        wr_reg(2'h1, 8'h01);
        wr_reg(2'h0, 8'h78);
        repeat (8) @(posedge i_clk);
        count_ticks(60);
        `CHK(in_rng(cnt, 29, 31), 1'b1)
        `CHK(in_rng(fcnt, 14, 16), 1'b1)
        `CHK(loop_s.cmp_periods, 8'h80)
        lock <= 1'b0;
        count_ticks(60);
        `CHK(in_rng(cnt, 29, 31), 1'b1)
        wr_reg(2'h1, 8'h11);
        repeat (4) @(posedge i_clk);
        count_ticks(60);
        `CHK(in_rng(cnt, 14, 16), 1'b1)
        stop <= 1'b1;
        repeat (4) @(posedge i_clk);
        count_ticks(40);
        `CHK(cnt, 0)
        rd_reg(2'h2, rd_v);
        `CHK(rd_v[1:0], 2'h0)
        close_out();
    end
endmodule : testbench
